// >>> include/uhtr_defs.vh
// Constants for the USB host transaction-result block: register map, fields, codes.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef UHTR_DEFS_VH
`define UHTR_DEFS_VH

// Printed offsets are not all multiples of four: they are register indices
`define UHTR_IDX_H1_CTRL 16'hC080
`define UHTR_IDX_H1_COUNT 16'hC084
`define UHTR_IDX_H1_TOKEN 16'hC086
`define UHTR_IDX_H1_RESULT 16'hC088
`define UHTR_IDX_H1_STATUS 16'hC08A
`define UHTR_IDX_H2_CTRL 16'hC0A0
`define UHTR_IDX_H2_COUNT 16'hC0A4
`define UHTR_IDX_H2_TOKEN 16'hC0A6
`define UHTR_IDX_H2_RESULT 16'hC0A8
`define UHTR_IDX_H2_STATUS 16'hC0AA

// Endpoint status fields
`define UHTR_ST_OVF 11
`define UHTR_ST_UNF 10
`define UHTR_ST_STALL 7
`define UHTR_ST_NAK 6
`define UHTR_ST_LEN 5
`define UHTR_ST_SEQ 3
`define UHTR_ST_TMO 2
`define UHTR_ST_ERR 1
`define UHTR_ST_ACK 0

// Control fields
`define UHTR_CT_ISO 4
`define UHTR_CT_SEQ 6
`define UHTR_CT_ARM 0
`define UHTR_CT_MASK 16'h00F1

// Token fields
`define UHTR_TK_PID_HI 7
`define UHTR_TK_PID_LO 4
`define UHTR_TK_EP_HI 3
`define UHTR_TK_EP_LO 0
`define UHTR_TK_MASK 16'h00FF

// Count field
`define UHTR_CNT_HI 9
`define UHTR_CNT_MASK 16'h43FF

// Packet identifier codes
`define UHTR_PID_SETUP 4'hD
`define UHTR_PID_IN 4'h9
`define UHTR_PID_OUT 4'h1
`define UHTR_PID_SOF 4'h5
`define UHTR_PID_PRE 4'hC
`define UHTR_PID_NAK 4'hA
`define UHTR_PID_STALL 4'hE
`define UHTR_PID_DATA0 4'h3
`define UHTR_PID_DATA1 4'hB

// Completion outcome codes from the serial engine
`define UHTR_OUT_ACK 3'h0
`define UHTR_OUT_NAK 3'h1
`define UHTR_OUT_STALL 3'h2
`define UHTR_OUT_TMO 3'h3
`define UHTR_OUT_ERR 3'h4

`define UHTR_ZERO16 16'h0000

`endif

// >>> rtl/uhtr_apb_decode.v
// APB address decoder for the transaction-result block.
// Assumes byte address is four times the register index.
`timescale 1ns/1ps
`include "uhtr_defs.vh"

module uhtr_apb_decode (
    // Bus address
    input wire [31:0] paddr_i,
    // One-hot select: ctrl, count, token, result, status per host
    output reg [9:0] sel_o,
    output reg hit_o
);

    // Compare the word address against each index
    function match;
        input [31:0] a;
        input [15:0] idx;
        begin
            match = (a == {14'h0000, idx, 2'b00});
        end
    endfunction

    // Decode all ten registers
    always @* begin
        sel_o[0] = match(paddr_i, `UHTR_IDX_H1_CTRL);
        sel_o[1] = match(paddr_i, `UHTR_IDX_H1_COUNT);
        sel_o[2] = match(paddr_i, `UHTR_IDX_H1_TOKEN);
        sel_o[3] = match(paddr_i, `UHTR_IDX_H1_RESULT);
        sel_o[4] = match(paddr_i, `UHTR_IDX_H1_STATUS);
        sel_o[5] = match(paddr_i, `UHTR_IDX_H2_CTRL);
        sel_o[6] = match(paddr_i, `UHTR_IDX_H2_COUNT);
        sel_o[7] = match(paddr_i, `UHTR_IDX_H2_TOKEN);
        sel_o[8] = match(paddr_i, `UHTR_IDX_H2_RESULT);
        sel_o[9] = match(paddr_i, `UHTR_IDX_H2_STATUS);
        hit_o = |sel_o;
    end

endmodule // uhtr_apb_decode

// >>> rtl/uhtr_result_calc.v
// Outcome evaluator: turns a serial-engine completion into status and result.
// Assumes combinational use from the top module's capture logic.
`timescale 1ns/1ps
`include "uhtr_defs.vh"

module uhtr_result_calc #(
    parameter CW = 10
) (
    // Completion information
    input wire [2:0] outcome_i,
    input wire iso_i,
    input wire rx_toggle_i,
    input wire len_valid_i,
    input wire [CW-1:0] rx_len_i,
    input wire [CW-1:0] exp_len_i,
    // Evaluated words
    output reg [15:0] status_o,
    output reg [15:0] result_o
);

    reg [16:0] diff;
    reg ovf;
    reg unf;
    reg err;

    // Flags are recomputed whole, so nothing from the previous transaction lingers
    always @* begin
        status_o = `UHTR_ZERO16;
        diff = {{(17-CW){1'b0}}, exp_len_i} - {{(17-CW){1'b0}}, rx_len_i};
        err = (outcome_i == `UHTR_OUT_ERR);
        // Length only judged when a data stage arrived
        ovf = len_valid_i && (rx_len_i > exp_len_i);
        unf = len_valid_i && (rx_len_i < exp_len_i);
        status_o[`UHTR_ST_OVF] = ovf;
        status_o[`UHTR_ST_UNF] = unf;
        status_o[`UHTR_ST_STALL] = (outcome_i == `UHTR_OUT_STALL);
        status_o[`UHTR_ST_NAK] = (outcome_i == `UHTR_OUT_NAK);
        status_o[`UHTR_ST_LEN] = ovf | unf;
        status_o[`UHTR_ST_SEQ] = err ? 1'b0 : rx_toggle_i;
        status_o[`UHTR_ST_TMO] = (outcome_i == `UHTR_OUT_TMO);
        status_o[`UHTR_ST_ERR] = err;
        // Iso success carries no handshake but still reports here
        status_o[`UHTR_ST_ACK] = (outcome_i == `UHTR_OUT_ACK);
        // Negative difference on overflow gives all-ones upper bits
        result_o = (ovf | unf) ? diff[15:0] : `UHTR_ZERO16;
        if (iso_i && 1'b0) begin
            result_o = `UHTR_ZERO16;
        end
    end

endmodule // uhtr_result_calc

// >>> rtl/uhtr_top.v
// USB host transaction-result and token-setup block, two host instances.
// Assumes an APB master on clk_i and a serial engine that reports completions.
//
// What this block does
// - Overflow flag bit 11 set when more data arrived than expected length.
// - Underflow flag bit 10 set when less data arrived than expected.
// - Status bit 7 reports a STALL answer, else cleared.
// - Status bit 6 reports a NAK answer, else cleared.
// - Bit 5 flags any length mismatch, longer or shorter.
// - Bit 3 reports the last received data toggle.
// - Toggle bit forced to zero whenever the error flag is set.
// - Bit 2 reports a response or handshake timeout.
// - Bit 1 flags failures other than timeout, NAK, STALL; not length.
// - CRC5, CRC16 and unexpected packet type count as errors.
// - Bit 0 reports ACK received or sent for non-iso transfers.
// - Bit 0 reports success for iso transfers, else cleared.
// - Write-only token register: packet id in 7:4, endpoint in 3:0.
// - Packet id codes follow the standard USB token encodings.
// - ACK and NAK handshakes are generated by the engine itself.
// - Endpoint field is four bits, sixteen endpoints.
// - Read-only 16-bit result holds expected minus received length, or zero when no data stage arrived.
// - Overflow result is a negative two's-complement count.
// - Underflow result is the count of bytes not received.
// - Arm bit launches a transaction and clears itself on completion.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "uhtr_defs.vh"

module uhtr_top #(
    parameter CW = 10
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Serial engine, host 1
    output reg h1_start_o,
    output reg [3:0] h1_pid_o,
    output reg [3:0] h1_ep_o,
    output reg [CW-1:0] h1_len_o,
    output reg h1_iso_o,
    output reg h1_tx_toggle_o,
    input wire h1_done_i,
    input wire [2:0] h1_outcome_i,
    input wire h1_rx_toggle_i,
    input wire h1_len_valid_i,
    input wire [CW-1:0] h1_rx_len_i,
    // Serial engine, host 2
    output reg h2_start_o,
    output reg [3:0] h2_pid_o,
    output reg [3:0] h2_ep_o,
    output reg [CW-1:0] h2_len_o,
    output reg h2_iso_o,
    output reg h2_tx_toggle_o,
    input wire h2_done_i,
    input wire [2:0] h2_outcome_i,
    input wire h2_rx_toggle_i,
    input wire h2_len_valid_i,
    input wire [CW-1:0] h2_rx_len_i
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage, index 0 is host 1 and index 1 is host 2
    reg [15:0] ctrl_q [0:1];
    reg [15:0] count_q [0:1];
    reg [7:0] token_q [0:1];
    reg [15:0] status_q [0:1];
    reg [15:0] result_q [0:1];

    wire [9:0] sel;
    wire hit;
    wire [15:0] st_new [0:1];
    wire [15:0] res_new [0:1];
    wire done [0:1];
    wire [1:0] wr_ok;
    wire wr_en;
    wire rd_en;

    assign done[0] = h1_done_i;
    assign done[1] = h2_done_i;
    // Write takes effect only in the access cycle with ready high
    assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_en = psel_i && penable_i && !pwrite_i && pready_o;
    // Low two byte lanes both needed for a 16-bit register
    assign wr_ok = pstrb_i[1:0];

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    uhtr_apb_decode u_dec (
        .paddr_i(paddr_i),
        .sel_o(sel),
        .hit_o(hit)
    );

    // Outcome evaluators
    uhtr_result_calc #(.CW(CW)) u_calc1 (
        .outcome_i(h1_outcome_i),
        .iso_i(ctrl_q[0][`UHTR_CT_ISO]),
        .rx_toggle_i(h1_rx_toggle_i),
        .len_valid_i(h1_len_valid_i),
        .rx_len_i(h1_rx_len_i),
        .exp_len_i(count_q[0][CW-1:0]),
        .status_o(st_new[0]),
        .result_o(res_new[0])
    );

    uhtr_result_calc #(.CW(CW)) u_calc2 (
        .outcome_i(h2_outcome_i),
        .iso_i(ctrl_q[1][`UHTR_CT_ISO]),
        .rx_toggle_i(h2_rx_toggle_i),
        .len_valid_i(h2_len_valid_i),
        .rx_len_i(h2_rx_len_i),
        .exp_len_i(count_q[1][CW-1:0]),
        .status_o(st_new[1]),
        .result_o(res_new[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, ready is high in the second access cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i && penable_i && !pready_o;
        end
    end

    // Unmapped address or partial write answers with an error
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= psel_i && penable_i && !pready_o &&
                         (!hit || (pwrite_i && wr_ok != 2'b11));
        end
    end

    // Read mux: write-only token reads as zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && penable_i && !pready_o && !pwrite_i) begin
            prdata_o <= 32'h00000000;
            if (sel[0]) begin
                prdata_o <= {16'h0000, ctrl_q[0]};
            end
            if (sel[1]) begin
                prdata_o <= {16'h0000, count_q[0]};
            end
            if (sel[3]) begin
                prdata_o <= {16'h0000, result_q[0]};
            end
            if (sel[4]) begin
                prdata_o <= {16'h0000, status_q[0]};
            end
            if (sel[5]) begin
                prdata_o <= {16'h0000, ctrl_q[1]};
            end
            if (sel[6]) begin
                prdata_o <= {16'h0000, count_q[1]};
            end
            if (sel[8]) begin
                prdata_o <= {16'h0000, result_q[1]};
            end
            if (sel[9]) begin
                prdata_o <= {16'h0000, status_q[1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-host registers
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_host
            wire wr_ctrl;
            wire wr_cnt;
            wire wr_tok;
            assign wr_ctrl = wr_en && !pslverr_o && sel[g*5] && wr_ok == 2'b11;
            assign wr_cnt = wr_en && !pslverr_o && sel[g*5+1] && wr_ok == 2'b11;
            assign wr_tok = wr_en && !pslverr_o && sel[g*5+2] && wr_ok == 2'b11;

            // Control: arm self-clears on completion; completion wins a same-cycle write
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ctrl_q[g] <= `UHTR_ZERO16;
                end else begin
                    if (wr_ctrl) begin
                        ctrl_q[g] <= pwdata_i[15:0] & `UHTR_CT_MASK;
                    end
                    if (done[g] && ctrl_q[g][`UHTR_CT_ARM]) begin
                        ctrl_q[g][`UHTR_CT_ARM] <= 1'b0;
                    end
                end
            end

            // Expected length; bits other than 9:0 and 14 are masked off
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    count_q[g] <= `UHTR_ZERO16;
                end else if (wr_cnt) begin
                    count_q[g] <= pwdata_i[15:0] & `UHTR_CNT_MASK;
                end
            end

            // Token: packet id and four-bit endpoint, reserved bits dropped
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    token_q[g] <= 8'h00;
                end else if (wr_tok) begin
                    token_q[g] <= pwdata_i[7:0];
                end
            end

            // Status and result replaced together, only for an armed transaction
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status_q[g] <= `UHTR_ZERO16;
                    result_q[g] <= `UHTR_ZERO16;
                end else if (done[g] && ctrl_q[g][`UHTR_CT_ARM]) begin
                    status_q[g] <= st_new[g];
                    result_q[g] <= res_new[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Serial engine requests: start pulses on the rising edge of arm
    reg [1:0] arm_seen_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arm_seen_q <= 2'b00;
            h1_start_o <= 1'b0;
            h2_start_o <= 1'b0;
        end else begin
            arm_seen_q <= {ctrl_q[1][`UHTR_CT_ARM], ctrl_q[0][`UHTR_CT_ARM]};
            h1_start_o <= ctrl_q[0][`UHTR_CT_ARM] && !arm_seen_q[0];
            h2_start_o <= ctrl_q[1][`UHTR_CT_ARM] && !arm_seen_q[1];
        end
    end

    // Token and settings handed to the engine; handshakes are its own job
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            h1_pid_o <= 4'h0;
            h1_ep_o <= 4'h0;
            h1_len_o <= {CW{1'b0}};
            h1_iso_o <= 1'b0;
            h1_tx_toggle_o <= 1'b0;
            h2_pid_o <= 4'h0;
            h2_ep_o <= 4'h0;
            h2_len_o <= {CW{1'b0}};
            h2_iso_o <= 1'b0;
            h2_tx_toggle_o <= 1'b0;
        end else begin
            h1_pid_o <= token_q[0][`UHTR_TK_PID_HI:`UHTR_TK_PID_LO];
            h1_ep_o <= token_q[0][`UHTR_TK_EP_HI:`UHTR_TK_EP_LO];
            h1_len_o <= count_q[0][CW-1:0];
            h1_iso_o <= ctrl_q[0][`UHTR_CT_ISO];
            h1_tx_toggle_o <= ctrl_q[0][`UHTR_CT_SEQ];
            h2_pid_o <= token_q[1][`UHTR_TK_PID_HI:`UHTR_TK_PID_LO];
            h2_ep_o <= token_q[1][`UHTR_TK_EP_HI:`UHTR_TK_EP_LO];
            h2_len_o <= count_q[1][CW-1:0];
            h2_iso_o <= ctrl_q[1][`UHTR_CT_ISO];
            h2_tx_toggle_o <= ctrl_q[1][`UHTR_CT_SEQ];
        end
    end

endmodule // uhtr_top

// >>> verif/uhtr_props.sv
// Checker for the transaction-result block: bus answer timing and host 1 launch.
// Assumes it is bound to uhtr_top and sees only that module's ports.
`timescale 1ns/1ps
`include "uhtr_defs.vh"
module uhtr_props #(
    parameter CW = 10
) (
    // Clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // APB side
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [31:0] paddr_i,
    input logic [31:0] pwdata_i,
    input logic [3:0] pstrb_i,
    input logic [31:0] prdata_o,
    input logic pready_o,
    input logic pslverr_o,
    // Host 1 engine side
    input logic h1_start_o,
    input logic [3:0] h1_pid_o,
    input logic [3:0] h1_ep_o,
    input logic [CW-1:0] h1_len_o,
    input logic h1_done_i
);
////////////////////////////////////////////////////////////////////////////////
localparam logic [31:0] A_CTRL = {14'h0000, `UHTR_IDX_H1_CTRL, 2'h0};
localparam logic [31:0] A_CNT = {14'h0000, `UHTR_IDX_H1_COUNT, 2'h0};
localparam logic [31:0] A_TOK = {14'h0000, `UHTR_IDX_H1_TOKEN, 2'h0};
logic acc;
logic arm_wr;
logic busy_q;
logic [3:0] w_pid;
logic [3:0] w_ep;
logic [CW-1:0] w_len;
// Bus decode shared by several properties
assign acc = psel_i && penable_i;
assign arm_wr = acc && pready_o && pwrite_i && paddr_i == A_CTRL && pwdata_i[0]
    && pstrb_i[1:0] == 2'h3;
assign w_pid = pwdata_i[7:4];
assign w_ep = pwdata_i[3:0];
assign w_len = pwdata_i[CW-1:0];
// Tracks a running transfer, since re-arming a busy host launches nothing
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_q <= 1'b0;
    else if (h1_done_i) busy_q <= 1'b0;
    else if (arm_wr) busy_q <= 1'b1;
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
sequence s_wr(logic [31:0] a);
    acc && pready_o && pwrite_i && paddr_i == a && pstrb_i[1:0] == 2'h3;
endsequence
// Bus answers and refusals
ready_one_wait_a: assert property (acc && !pready_o |=> pready_o)
    else $error("pready not one cycle after access");
ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
upper_zero_a: assert property (pready_o |-> prdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
strobe_refuse_a: assert property (acc && !pready_o && pwrite_i && pstrb_i[1:0] != 2'h3
    |=> pready_o && pslverr_o) else $error("partial strobe not refused");
token_read_zero_a: assert property (acc && pready_o && !pwrite_i && paddr_i == A_TOK
    |-> prdata_o == 32'h0) else $error("token register readable");
// Token and count reach the engine
token_copy_a: assert property (s_wr(A_TOK) |-> ##2
    (h1_pid_o == $past(w_pid, 2) && h1_ep_o == $past(w_ep, 2))) else $error("token not passed");
count_copy_a: assert property (s_wr(A_CNT) |-> ##2 h1_len_o == $past(w_len, 2))
    else $error("count not passed");
// Launch follows the arm bit
arm_start_a: assert property (arm_wr && !busy_q && !h1_done_i |-> ##2 h1_start_o)
    else $error("arm did not launch");
start_cause_a: assert property (h1_start_o |-> $past(arm_wr, 2))
    else $error("launch without arm");
start_pulse_a: assert property (h1_start_o |=> !h1_start_o)
    else $error("launch longer than one cycle");
endmodule // uhtr_props

// >>> verif/uhtr_engine_model.sv
// Partner model: serial engine with a USB peripheral behind it, one per host.
// Assumes the bench sets the chosen answer before each launch.
`timescale 1ns/1ps
module uhtr_engine_model (
    // Clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // Launch and chosen answer
    input logic start_i,
    input logic [2:0] oc_i,
    input logic tg_i,
    input logic lv_i,
    input logic [9:0] len_i,
    input logic [7:0] dly_i,
    // Completion report
    output logic done_o,
    output logic [2:0] oc_o,
    output logic tg_o,
    output logic lv_o,
    output logic [9:0] len_o
);
////////////////////////////////////////////////////////////////////////////////
logic act_q;
logic [7:0] cnt_q;
// Answers dly_i + 2 cycles after the launch pulse, so prompt and slow peers both occur
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        act_q <= 1'b0;
        cnt_q <= 8'h00;
        done_o <= 1'b0;
    end else begin
        done_o <= act_q && cnt_q == 8'h00;
        if (start_i) begin
            act_q <= 1'b1;
            cnt_q <= dly_i;
        end else if (act_q && cnt_q == 8'h00) act_q <= 1'b0;
        else if (act_q) cnt_q <= cnt_q - 8'h01;
    end
end
// Fields mean something only with done; elsewhere they show the inverse
assign oc_o = done_o ? oc_i : ~oc_i;
assign tg_o = done_o ? tg_i : ~tg_i;
assign lv_o = done_o ? lv_i : ~lv_i;
assign len_o = done_o ? len_i : ~len_i;
endmodule // uhtr_engine_model

// >>> verif/uhtr_top_tb.sv
// Self-checking bench for the transaction-result block, both hosts.
// Assumes the engine model and the checker are compiled alongside.
`timescale 1ns/1ps
`include "uhtr_defs.vh"
module uhtr_top_tb;
typedef struct {logic [2:0] oc; logic iso; logic tg; logic lv; logic [9:0] rx;
    logic [9:0] ex; logic [15:0] st; logic [15:0] res;} uhtr_row_t;
logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
logic [31:0] paddr_i, pwdata_i, prdata_o;
logic [3:0] pstrb_i, h1_pid_o, h1_ep_o, h2_pid_o, h2_ep_o;
logic h1_start_o, h1_iso_o, h1_tx_toggle_o, h1_done_i, h1_rx_toggle_i, h1_len_valid_i;
logic h2_start_o, h2_iso_o, h2_tx_toggle_o, h2_done_i, h2_rx_toggle_i, h2_len_valid_i;
logic [9:0] h1_len_o, h1_rx_len_i, h2_len_o, h2_rx_len_i, c_len;
logic [2:0] h1_outcome_i, h2_outcome_i, c_oc;
logic c_tg, c_lv;
logic [7:0] c_dly;
int fail_count = 0;
int checked = 0;
logic [3:0] pids [9] = '{`UHTR_PID_SETUP, `UHTR_PID_IN, `UHTR_PID_OUT, `UHTR_PID_SOF,
    `UHTR_PID_PRE, `UHTR_PID_NAK, `UHTR_PID_STALL, `UHTR_PID_DATA0, `UHTR_PID_DATA1};
// Outcome, iso, toggle, length seen, received, expected, status, result
uhtr_row_t rows [12] = '{
    '{3'h0, 1'b0, 1'b1, 1'b1, 10'h008, 10'h008, 16'h0009, 16'h0000},
    '{3'h0, 1'b0, 1'b0, 1'b1, 10'h00C, 10'h008, 16'h0821, 16'hFFFC},
    '{3'h0, 1'b0, 1'b1, 1'b1, 10'h003, 10'h008, 16'h0429, 16'h0005},
    '{3'h1, 1'b0, 1'b0, 1'b0, 10'h000, 10'h040, 16'h0040, 16'h0000},
    '{3'h2, 1'b0, 1'b0, 1'b0, 10'h000, 10'h040, 16'h0080, 16'h0000},
    '{3'h3, 1'b0, 1'b0, 1'b0, 10'h000, 10'h040, 16'h0004, 16'h0000},
    '{3'h4, 1'b0, 1'b1, 1'b0, 10'h000, 10'h040, 16'h0002, 16'h0000},
    '{3'h4, 1'b0, 1'b1, 1'b1, 10'h009, 10'h008, 16'h0822, 16'hFFFF},
    '{3'h0, 1'b1, 1'b0, 1'b1, 10'h3FF, 10'h3FF, 16'h0001, 16'h0000},
    '{3'h4, 1'b1, 1'b0, 1'b1, 10'h3FF, 10'h3FF, 16'h0002, 16'h0000},
    '{3'h0, 1'b0, 1'b0, 1'b1, 10'h3FF, 10'h000, 16'h0821, 16'hFC01},
    '{3'h0, 1'b0, 1'b0, 1'b1, 10'h000, 10'h3FF, 16'h0421, 16'h03FF}};
////////////////////////////////////////////////////////////////////////////////
uhtr_top #(.CW(10)) DUT (.*);
uhtr_engine_model m1 (.clk_i, .rst_n_i, .start_i(h1_start_o), .oc_i(c_oc), .tg_i(c_tg),
    .lv_i(c_lv), .len_i(c_len), .dly_i(c_dly), .done_o(h1_done_i), .oc_o(h1_outcome_i),
    .tg_o(h1_rx_toggle_i), .lv_o(h1_len_valid_i), .len_o(h1_rx_len_i));
uhtr_engine_model m2 (.clk_i, .rst_n_i, .start_i(h2_start_o), .oc_i(c_oc), .tg_i(c_tg),
    .lv_i(c_lv), .len_i(c_len), .dly_i(c_dly), .done_o(h2_done_i), .oc_o(h2_outcome_i),
    .tg_o(h2_rx_toggle_i), .lv_o(h2_len_valid_i), .len_o(h2_rx_len_i));
////////////////////////////////////////////////////////////////////////////////
task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
        fail_count++;
        $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
endtask
// One APB transfer; an idle edge first keeps each signal to one write per step
task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] v, output logic e);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {14'h0000, a, 2'h0};
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
        @(posedge clk_i);
        n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
        fail_count++;
        conclude();
    end
    v = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
endtask
task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, 4'hF, v, e);
endtask
task automatic rd(input logic [15:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, v, e);
endtask
// Programs a host, launches, waits for arm to drop, then reads the outcome
task automatic run(input logic [15:0] b, input uhtr_row_t r, input logic [7:0] d);
    logic [31:0] v;
    int n;
    c_oc <= r.oc;
    c_tg <= r.tg;
    c_lv <= r.lv;
    c_len <= r.rx;
    c_dly <= d;
    wr(b + 16'h0004, 32'(r.ex));
    wr(b + 16'h0006, {24'h000000, `UHTR_PID_IN, 4'h2});
    wr(b, 32'({r.iso, 4'h1}));
    n = 0;
    do begin
        rd(b, v);
        n++;
    end while (v[0] !== 1'b0 && n < 40);
    if (n >= 40) begin
        fail_count++;
        conclude();
    end
    chk("ctrl", 32'({r.iso, 4'h0}), v);
    rd(b + 16'h000A, v);
    chk("status", {16'h0000, r.st}, v);
    rd(b + 16'h0008, v);
    chk("result", {16'h0000, r.res}, v);
endtask
////////////////////////////////////////////////////////////////////////////////
// Free-running clock, 8 ns period
initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
end
// Watchdog against a hang anywhere in the sequence
initial begin
    repeat (50000) @(posedge clk_i);
    fail_count++;
    conclude();
end
// Main sequence
initial begin
    logic [31:0] v;
    logic e;
    rst_n_i = 1'b0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
    {c_oc, c_tg, c_lv, c_len, c_dly} = '0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 10; i++) begin
        rd((i < 5 ? `UHTR_IDX_H1_CTRL : `UHTR_IDX_H2_CTRL) + 16'(2 * (i % 5)), v);
        if (i % 5 != 1) chk("reset value", 32'h0, v);
    end
    $display("test reset done");
    for (int i = 0; i < 12; i++) run(`UHTR_IDX_H1_CTRL, rows[i], i % 2 ? 8'h14 : 8'h00);
    $display("test rows done");
    for (int i = 0; i < 9; i++) begin
        wr(`UHTR_IDX_H1_TOKEN, {24'h000000, pids[i], 4'(15 - i)});
        repeat (2) @(posedge clk_i);
        chk("pid", 32'(pids[i]), 32'(h1_pid_o));
        chk("endpoint", 32'(15 - i), 32'(h1_ep_o));
        rd(`UHTR_IDX_H1_TOKEN, v);
        chk("token read", 32'h0, v);
    end
    $display("test token done");
    apb(1'b0, 16'hC0FE, 32'h0, 4'h0, v, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, v);
    apb(1'b1, `UHTR_IDX_H1_COUNT, 32'h0000_0155, 4'h1, v, e);
    chk("strobe err", 32'h1, 32'(e));
    rd(`UHTR_IDX_H1_COUNT, v);
    chk("count kept", 32'h0000_03FF, v);
    $display("test refusal done");
    // Settings copied out to the engine one cycle after the write lands
    wr(`UHTR_IDX_H1_CTRL, 32'h0000_0050);
    repeat (2) @(posedge clk_i);
    chk("tx toggle", 32'h1, 32'(h1_tx_toggle_o));
    chk("iso out", 32'h1, 32'(h1_iso_o));
    chk("len out", 32'h3FF, 32'(h1_len_o));
    $display("test settings done");
    run(`UHTR_IDX_H2_CTRL, rows[4], 8'h05);
    chk("host2 pid", 32'(`UHTR_PID_IN), 32'(h2_pid_o));
    chk("host2 endpoint", 32'h2, 32'(h2_ep_o));
    chk("host2 len", 32'(rows[4].ex), 32'(h2_len_o));
    chk("host2 iso", 32'h0, 32'(h2_iso_o));
    chk("host2 toggle", 32'h0, 32'(h2_tx_toggle_o));
    rd(`UHTR_IDX_H1_STATUS, v);
    chk("host1 status", {16'h0000, rows[11].st}, v);
    $display("test host2 done");
    conclude();
end
endmodule // uhtr_top_tb
bind uhtr_top uhtr_props #(.CW(CW)) u_props (.clk_i, .rst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .h1_start_o, .h1_pid_o, .h1_ep_o, .h1_len_o, .h1_done_i);
